/* File: rtl/mvw_regs.vh */
// Purpose: constants for the vlan tag and wake-up filter block
// Assumes: apb byte addresses are four times the register index
// Notes: single include, definitions only
//
// Notes on behaviour
// [RULE1] first tag identifier is compared with received frame bytes 13 and 14.
// [RULE2] second tag identifier is compared with bytes 13 and 14, on its own.
// [RULE3] tagged frames are legal up to 1522 bytes instead of 1518.
// [RULE4] software writes 0x8100 into a tag identifier it uses; both reset zero.
// [RULE5] successive filter port writes fill entries zero, one, two and onward.
// [RULE6] after eight entries the filter write pointer wraps back to entry zero.
// [RULE7] power-on, hardware or soft reset puts the filter pointer at entry zero.
// [RULE8] filter port is write only; reading it never shows entry contents.
// [RULE9] global unicast enable wakes on frames whose destination bit 0 is zero.
// [RULE10] valid wake-up frame sets the wake frame received status bit.
// [RULE11] valid magic packet sets the magic packet received status bit.
// [RULE12] wake frame enable matches frames against the programmed filter entries.
// [RULE13] magic packet enable allows magic packet wake; clear blocks it.
// [RULE14] both received status bits stay set until software clears or reset.
`ifndef MVW_REGS_VH
`define MVW_REGS_VH
`define MVW_IDX_TAG1 4'h9
`define MVW_IDX_TAG2 4'ha
`define MVW_IDX_FILT 4'hb
`define MVW_IDX_WCSR 4'hc
`define MVW_ADDR_W 8
`define MVW_ADDR_TAG1 8'h24
`define MVW_ADDR_TAG2 8'h28
`define MVW_ADDR_FILT 8'h2c
`define MVW_ADDR_WCSR 8'h30
`define MVW_RST_WORD 32'h0000_0000
`define MVW_BIT_GUWE 9
`define MVW_BIT_WFR 6
`define MVW_BIT_MPRX 5
`define MVW_BIT_WEN 2
`define MVW_BIT_MPON 1
`define MVW_TAG_POS_HI 16'h000c
`define MVW_TAG_POS_LO 16'h000d
`define MVW_LEN_PLAIN 16'd1518
`define MVW_LEN_VLAN 16'd1522
`define MVW_ENTRY_CMD 3'h4
`define MVW_ENTRY_OFS 3'h5
`define MVW_ENTRY_CRC01 3'h6
`define MVW_ENTRY_CRC23 3'h7
`define MVW_MAGIC_SYNC 3'h6
`define MVW_MAGIC_REPS 4'hf
`define MVW_MAGIC_LAST 3'h5
`define MVW_CRC_POLY 16'h8005
`define MVW_CRC_INIT 16'hffff
`endif

/* File: rtl/mvw_tag_wake.v */
// Purpose: vlan tag detection, frame length limit, wake-up filter and wake status
// Assumes: rx bytes synchronous to sys_clk, one byte per rx_valid, frame ends on rx_eof
// Notes: apb slave answers in the second access cycle; no interrupt logic
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "mvw_regs.vh"

// one wake filter: crc-16 over masked bytes from a byte offset
module mvw_wake_crc
(
  input wire sys_clk,
  input wire arst_n,
  input wire clr,
  input wire byte_en,
  input wire [15:0] byte_idx,
  input wire [7:0] byte_in,
  input wire [31:0] mask,
  input wire [7:0] offset,
  output reg [15:0] crc_q
);
  reg [15:0] rel;
  reg [15:0] nxt;
  reg hit;
  integer i;

  always @*
  begin
    rel = byte_idx - {8'h00, offset};
    hit = byte_en && (byte_idx >= {8'h00, offset}) && (rel < 16'd32) && mask[rel[4:0]];
    // restart at the first byte of a frame without losing that byte
    nxt = clr ? `MVW_CRC_INIT : crc_q;
    for (i = 0; i < 8; i = i + 1)
    begin
      if (nxt[15] ^ byte_in[i])
        nxt = {nxt[14:0], 1'b0} ^ `MVW_CRC_POLY;
      else
        nxt = {nxt[14:0], 1'b0};
    end
  end

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      crc_q <= `MVW_CRC_INIT;
    else if (hit)
      crc_q <= nxt;
    else if (clr)
      crc_q <= `MVW_CRC_INIT;
  end
endmodule

module mvw_tag_wake
#(
  parameter N_ENTRY = 8,
  parameter N_FILT = 4
)
(
  input wire sys_clk,
  input wire arst_n,
  input wire soft_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`MVW_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_q,
  output reg pready_q,
  output reg pslverr_q,
  input wire rx_valid,
  input wire rx_sof,
  input wire rx_eof,
  input wire rx_err,
  input wire [7:0] rx_data,
  input wire [47:0] mac_addr,
  input wire power_save,
  output reg first_vlan_tag_frame_q,
  output reg second_vlan_tag_frame_q,
  output reg len_err_q,
  output reg wake_q
);
  reg [15:0] first_vlan_tag_q;
  reg [15:0] second_vlan_tag_q;
  reg [31:0] wake_filter_entry_q [0:N_ENTRY-1];
  reg [2:0] wptr_q;
  reg global_unicast_wake_enable_q;
  reg wake_frame_received_q;
  reg magic_packet_received_q;
  reg wake_frame_enable_q;
  reg magic_packet_enable_q;
  reg [15:0] byte_cnt_q;
  reg [7:0] tag_hi_q;
  reg unicast_q;
  reg [2:0] ff_run_q;
  reg mp_act_q;
  reg [2:0] mp_pos_q;
  reg [3:0] mp_rep_q;
  reg mp_found_q;
  wire [15:0] idx;
  wire [15:0] crc_w [0:N_FILT-1];
  wire [N_FILT-1:0] filt_ok;
  wire acc;
  wire wr;
  wire map_hit;
  wire wcsr_wr;
  wire frm_end;
  wire frame_vlan;
  wire mp_done;
  wire wake_frame_ok;
  wire gu_ok;
  reg [7:0] mp_exp;
  reg [31:0] rd_d;
  reg [15:0] tag_word;
  integer k;

  assign acc = psel && penable && !pready_q;
  assign wr = acc && pwrite;
  assign map_hit = (paddr == `MVW_ADDR_TAG1) || (paddr == `MVW_ADDR_TAG2) ||
                   (paddr == `MVW_ADDR_FILT) || (paddr == `MVW_ADDR_WCSR);
  assign wcsr_wr = wr && (paddr == `MVW_ADDR_WCSR);
  assign idx = rx_sof ? 16'h0000 : byte_cnt_q;
  assign frm_end = rx_valid && rx_eof;

  // apb slave: pready one cycle into the access phase, so answers are registered
  always @*
  begin
    rd_d = `MVW_RST_WORD;
    case (paddr)
      `MVW_ADDR_TAG1: rd_d[15:0] = first_vlan_tag_q;
      `MVW_ADDR_TAG2: rd_d[15:0] = second_vlan_tag_q;
      `MVW_ADDR_FILT: rd_d = `MVW_RST_WORD; // RULE8
      `MVW_ADDR_WCSR:
      begin
        rd_d[`MVW_BIT_GUWE] = global_unicast_wake_enable_q;
        rd_d[`MVW_BIT_WFR] = wake_frame_received_q;
        rd_d[`MVW_BIT_MPRX] = magic_packet_received_q;
        rd_d[`MVW_BIT_WEN] = wake_frame_enable_q;
        rd_d[`MVW_BIT_MPON] = magic_packet_enable_q;
      end
      default: rd_d = `MVW_RST_WORD;
    endcase
  end

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= `MVW_RST_WORD;
    end
    else
    begin
      pready_q <= acc;
      pslverr_q <= acc && !map_hit;
      prdata_q <= (acc && !pwrite) ? rd_d : `MVW_RST_WORD;
    end
  end

  // control registers; soft reset returns them to their reset values
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      first_vlan_tag_q <= 16'h0000;
      second_vlan_tag_q <= 16'h0000;
      global_unicast_wake_enable_q <= 1'b0;
      wake_frame_enable_q <= 1'b0;
      magic_packet_enable_q <= 1'b0;
    end
    else if (soft_rst)
    begin
      first_vlan_tag_q <= 16'h0000;
      second_vlan_tag_q <= 16'h0000;
      global_unicast_wake_enable_q <= 1'b0;
      wake_frame_enable_q <= 1'b0;
      magic_packet_enable_q <= 1'b0;
    end
    else if (wr)
    begin
      if (paddr == `MVW_ADDR_TAG1)
        first_vlan_tag_q <= pwdata[15:0];
      if (paddr == `MVW_ADDR_TAG2)
        second_vlan_tag_q <= pwdata[15:0];
      if (wcsr_wr)
      begin
        global_unicast_wake_enable_q <= pwdata[`MVW_BIT_GUWE];
        wake_frame_enable_q <= pwdata[`MVW_BIT_WEN];
        magic_packet_enable_q <= pwdata[`MVW_BIT_MPON];
      end
    end
  end

  // filter entries behind one write port with a wrapping pointer
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      wptr_q <= 3'h0; // RULE7
    else if (soft_rst)
      wptr_q <= 3'h0; // RULE7
    else if (wr && (paddr == `MVW_ADDR_FILT))
      wptr_q <= wptr_q + 3'h1; // RULE6
  end

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (k = 0; k < N_ENTRY; k = k + 1)
        wake_filter_entry_q[k] <= `MVW_RST_WORD;
    end
    else if (wr && (paddr == `MVW_ADDR_FILT))
      wake_filter_entry_q[wptr_q] <= pwdata; // RULE5
  end

  // frame byte counter and tag capture
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      byte_cnt_q <= 16'h0000;
      tag_hi_q <= 8'h00;
      unicast_q <= 1'b0;
    end
    else if (rx_valid)
    begin
      byte_cnt_q <= rx_eof ? 16'h0000 : idx + 16'h0001;
      if (idx == `MVW_TAG_POS_HI)
        tag_hi_q <= rx_data;
      if (idx == 16'h0000)
        unicast_q <= !rx_data[0];
    end
  end

  always @*
  begin
    tag_word = {tag_hi_q, rx_data};
  end

  // tag flags hold from byte 14 until the first byte of the next frame
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      first_vlan_tag_frame_q <= 1'b0;
      second_vlan_tag_frame_q <= 1'b0;
    end
    else if (rx_valid && rx_sof)
    begin
      first_vlan_tag_frame_q <= 1'b0;
      second_vlan_tag_frame_q <= 1'b0;
    end
    else if (rx_valid && (idx == `MVW_TAG_POS_LO))
    begin
      first_vlan_tag_frame_q <= (tag_word == first_vlan_tag_q); // RULE1
      second_vlan_tag_frame_q <= (tag_word == second_vlan_tag_q); // RULE2
    end
  end

  // length is idx+1 at the last byte; a one-byte frame never reaches the tag bytes
  assign frame_vlan = first_vlan_tag_frame_q || second_vlan_tag_frame_q;

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      len_err_q <= 1'b0;
    else
      len_err_q <= frm_end && ((idx + 16'h0001) >
                   (frame_vlan ? `MVW_LEN_VLAN : `MVW_LEN_PLAIN)); // RULE3
  end

  // magic packet: six 0xff then sixteen copies of the station address
  always @*
  begin
    case (mp_pos_q)
      3'h0: mp_exp = mac_addr[47:40];
      3'h1: mp_exp = mac_addr[39:32];
      3'h2: mp_exp = mac_addr[31:24];
      3'h3: mp_exp = mac_addr[23:16];
      3'h4: mp_exp = mac_addr[15:8];
      3'h5: mp_exp = mac_addr[7:0];
      default: mp_exp = 8'h00;
    endcase
  end

  assign mp_done = mp_act_q && (rx_data == mp_exp) &&
                   (mp_pos_q == `MVW_MAGIC_LAST) && (mp_rep_q == `MVW_MAGIC_REPS);

  // a broken copy restarts the search; bytes of that copy are not rescanned
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ff_run_q <= 3'h0;
      mp_act_q <= 1'b0;
      mp_pos_q <= 3'h0;
      mp_rep_q <= 4'h0;
      mp_found_q <= 1'b0;
    end
    else if (rx_valid)
    begin
      if (rx_data != 8'hff)
        ff_run_q <= 3'h0;
      else if (ff_run_q != `MVW_MAGIC_SYNC)
        ff_run_q <= ff_run_q + 3'h1;
      if (rx_sof)
        mp_found_q <= 1'b0;
      if (mp_done)
        mp_found_q <= 1'b1;
      if (rx_eof || rx_sof)
      begin
        mp_act_q <= 1'b0;
        mp_pos_q <= 3'h0;
        mp_rep_q <= 4'h0;
      end
      else if (mp_act_q && (rx_data == mp_exp) && !mp_done)
      begin
        mp_pos_q <= (mp_pos_q == `MVW_MAGIC_LAST) ? 3'h0 : mp_pos_q + 3'h1;
        if (mp_pos_q == `MVW_MAGIC_LAST)
          mp_rep_q <= mp_rep_q + 4'h1;
      end
      else if (!mp_act_q && (ff_run_q == `MVW_MAGIC_SYNC) && (rx_data == mac_addr[47:40]))
      begin
        mp_act_q <= 1'b1;
        mp_pos_q <= 3'h1;
        mp_rep_q <= 4'h0;
      end
      else
      begin
        mp_act_q <= 1'b0;
        mp_pos_q <= 3'h0;
        mp_rep_q <= 4'h0;
      end
    end
  end

  // wake filters: entries 0-3 masks, 4 enables, 5 offsets, 6-7 expected crcs
  genvar g;
  generate
    for (g = 0; g < N_FILT; g = g + 1)
    begin : filt
      mvw_wake_crc u_crc
      (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .clr(rx_valid && rx_sof),
        .byte_en(rx_valid),
        .byte_idx(idx),
        .byte_in(rx_data),
        .mask(wake_filter_entry_q[g]),
        .offset(wake_filter_entry_q[`MVW_ENTRY_OFS][8*g+7:8*g]),
        .crc_q(crc_w[g])
      );
      assign filt_ok[g] = wake_filter_entry_q[`MVW_ENTRY_CMD][8*g] &&
        (crc_w[g] == wake_filter_entry_q[`MVW_ENTRY_CRC01 + g/2][16*(g%2)+15:16*(g%2)]);
    end
  endgenerate

  // filters judge crc at frame end, so the last byte must lie outside every mask
  assign wake_frame_ok = frm_end && !rx_err && wake_frame_enable_q && (|filt_ok); // RULE12
  assign gu_ok = frm_end && !rx_err && global_unicast_wake_enable_q && unicast_q; // RULE9

  // status: set wins over a write-one clear in the same cycle
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wake_frame_received_q <= 1'b0;
      magic_packet_received_q <= 1'b0;
    end
    else if (soft_rst)
    begin
      wake_frame_received_q <= 1'b0;
      magic_packet_received_q <= 1'b0;
    end
    else
    begin
      if (wake_frame_ok)
        wake_frame_received_q <= 1'b1; // RULE10
      else if (wcsr_wr && pwdata[`MVW_BIT_WFR])
        wake_frame_received_q <= 1'b0; // RULE14
      if (frm_end && !rx_err && magic_packet_enable_q && (mp_found_q || mp_done))
        magic_packet_received_q <= 1'b1; // RULE11 RULE13
      else if (wcsr_wr && pwdata[`MVW_BIT_MPRX])
        magic_packet_received_q <= 1'b0; // RULE14
    end
  end

  // wake pulse only while the system sleeps
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      wake_q <= 1'b0;
    else
      wake_q <= power_save && (wake_frame_ok || gu_ok ||
                (frm_end && !rx_err && magic_packet_enable_q && (mp_found_q || mp_done)));
  end
endmodule

/* File: tb/mvw_rx_src.sv */
// Purpose: network-side frame source for the tag and wake block
// Assumes: one byte per cycle, destination address first
// Notes: idle data shows the inverse of the last byte, never a stale value
`timescale 1ns/1ps
module mvw_rx_src
(
  input wire sys_clk,
  input wire [47:0] mac_addr,
  output logic rx_valid,
  output logic rx_sof,
  output logic rx_eof,
  output logic rx_err,
  output logic [7:0] rx_data
);
  initial
  begin
    rx_valid = 0;
    rx_sof = 0;
    rx_eof = 0;
    rx_err = 0;
    rx_data = 8'h00;
  end
  // bytes 13 and 14 carry the tag; magic sync and address copies follow
  task send(input int len, input logic [15:0] tag, input logic [7:0] b1, input bit mg,
    input bit bad);
    int i;
    logic [7:0] b;
    for (i = 1; i <= len; i++)
    begin
      b = 8'h55;
      if (i == 1) b = b1;
      else if (i <= 12) b = 8'h02;
      else if (i == 13) b = tag[15:8];
      else if (i == 14) b = tag[7:0];
      else if (mg && i <= 20) b = 8'hff;
      else if (mg && i <= 116) b = mac_addr[47 - 8 * ((i - 21) % 6) -: 8];
      @(posedge sys_clk);
      rx_valid <= 1;
      rx_sof <= (i == 1);
      rx_eof <= (i == len);
      rx_err <= bad && (i == len);
      rx_data <= b;
    end
    @(posedge sys_clk);
    rx_valid <= 0;
    rx_sof <= 0;
    rx_eof <= 0;
    rx_err <= 0;
    rx_data <= ~b;
  endtask
endmodule

/* File: tb/mvw_tag_wake_chk.sv */
// Purpose: port-level checks for the tag and wake block
// Assumes: apb address held through the ready cycle
// Notes: tag flags are not cleared by soft reset, yet the holds still exclude it
`timescale 1ns/1ps
`include "mvw_regs.vh"
module mvw_tag_wake_chk
(
  input wire sys_clk,
  input wire arst_n,
  input wire soft_rst,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata_q,
  input wire pready_q,
  input wire pslverr_q,
  input wire rx_valid,
  input wire rx_sof,
  input wire rx_eof,
  input wire power_save,
  input wire first_vlan_tag_frame_q,
  input wire second_vlan_tag_frame_q,
  input wire len_err_q,
  input wire wake_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire flt_rd = pready_q && !pwrite && paddr == `MVW_ADDR_FILT;
  a_filter_rd_zero: assert property (flt_rd |-> prdata_q == 32'h0)
    else $error("filter port read shows data");
  a_filter_no_err: assert property (pready_q && paddr == `MVW_ADDR_FILT |-> !pslverr_q)
    else $error("filter port access flagged");
  a_wake_cause: assert property (wake_q |-> $past(rx_valid && rx_eof && power_save))
    else $error("wake without end of frame");
  a_wake_pulse: assert property (wake_q |=> !wake_q)
    else $error("wake longer than one cycle");
  a_len_cause: assert property (len_err_q |-> $past(rx_valid && rx_eof))
    else $error("length error without end of frame");
  a_len_pulse: assert property (len_err_q |=> !len_err_q)
    else $error("length error longer than one cycle");
  a_tag1_hold: assert property (first_vlan_tag_frame_q && !rx_sof && !soft_rst |=> first_vlan_tag_frame_q)
    else $error("first tag flag dropped");
  a_tag2_hold: assert property (second_vlan_tag_frame_q && !rx_sof && !soft_rst |=> second_vlan_tag_frame_q)
    else $error("second tag flag dropped");
  a_tag_sof_clr: assert property (rx_valid && rx_sof |=> !first_vlan_tag_frame_q && !second_vlan_tag_frame_q)
    else $error("tag flag kept over new frame");
endmodule
bind mvw_tag_wake mvw_tag_wake_chk mvw_tag_wake_chk_i (.sys_clk, .arst_n, .soft_rst, .pwrite,
  .paddr, .prdata_q, .pready_q, .pslverr_q, .rx_valid, .rx_sof, .rx_eof, .power_save,
  .first_vlan_tag_frame_q, .second_vlan_tag_frame_q, .len_err_q, .wake_q);

/* File: tb/testbench.sv */
// Purpose: apb and frame sequences against the tag and wake block
// Assumes: a zero filter mask leaves the crc at its start value
// Notes: frame checks sample flags one cycle after the last byte
`timescale 1ns/1ps
`include "mvw_regs.vh"
module testbench;
  logic sys_clk = 0, arst_n = 0, soft_rst = 0, psel = 0, penable = 0, pwrite = 0;
  logic power_save = 0, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [47:0] mac_addr = 48'h0200_1122_3344;
  wire [31:0] prdata_q;
  wire [7:0] rx_data;
  wire pready_q, pslverr_q, rx_valid, rx_sof, rx_eof, rx_err;
  wire first_vlan_tag_frame_q, second_vlan_tag_frame_q, len_err_q, wake_q;
  int error_cnt = 0, n_tests = 0, k;
  initial forever #50 sys_clk = ~sys_clk;
  mvw_tag_wake mvw_tag_wake_i (.sys_clk, .arst_n, .soft_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata_q, .pready_q, .pslverr_q, .rx_valid, .rx_sof, .rx_eof, .rx_err, .rx_data,
    .mac_addr, .power_save, .first_vlan_tag_frame_q, .second_vlan_tag_frame_q, .len_err_q, .wake_q);
  mvw_rx_src mvw_rx_src_i (.sys_clk, .mac_addr, .rx_valid, .rx_sof, .rx_eof, .rx_err, .rx_data);
  task finish_test;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    for (t = 0; t < 20; t++)
    begin
      @(posedge sys_clk);
      if (pready_q === 1'b1) break;
    end
    if (t == 20)
    begin
      error_cnt++;
      finish_test;
    end
    rd = prdata_q;
    er = pslverr_q;
    psel <= 0;
    penable <= 0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(rd, e);
  endtask
  // expect is {first tag, second tag, length error, wake}
  task frm(input int len, input logic [15:0] tag, input logic [7:0] b1, input bit mg,
    input bit bad, input logic [3:0] e);
    mvw_rx_src_i.send(len, tag, b1, mg, bad);
    @(negedge sys_clk);
    chk({28'h0, first_vlan_tag_frame_q, second_vlan_tag_frame_q, len_err_q, wake_q}, {28'h0, e});
  endtask
  // entry 4 enables filter 0, entry 6 holds its expected crc
  task flt(input bit en);
    for (k = 0; k < 8; k++)
      apb(1, `MVW_ADDR_FILT, k == 4 ? {31'h0, en} : (k == 6 ? 32'h0000_ffff : 32'h0));
  endtask
  initial
  begin
    #5_000_000;
    error_cnt++;
    finish_test;
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    arst_n <= 1;
    power_save <= 1;
    rdc(`MVW_ADDR_TAG1, 32'h0);
    rdc(`MVW_ADDR_TAG2, 32'h0);
    rdc(`MVW_ADDR_FILT, 32'h0);
    rdc(`MVW_ADDR_WCSR, 32'h0);
    apb(1, `MVW_ADDR_TAG1, 32'hffff_8100);
    apb(1, `MVW_ADDR_TAG2, 32'h0000_88a8);
    rdc(`MVW_ADDR_TAG1, 32'h0000_8100);
    rdc(`MVW_ADDR_TAG2, 32'h0000_88a8);
    apb(0, 8'h34, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    frm(1522, 16'h8100, 8'h01, 0, 0, 4'b1000);
    frm(1523, 16'h8100, 8'h01, 0, 0, 4'b1010);
    frm(1522, 16'h88a8, 8'h01, 0, 0, 4'b0100);
    frm(1519, 16'h0800, 8'h01, 0, 0, 4'b0010);
    frm(1518, 16'h0800, 8'h01, 0, 0, 4'b0000);
    frm(64, 16'h0800, 8'h00, 0, 0, 4'b0000);
    apb(1, `MVW_ADDR_WCSR, 32'h200);
    frm(64, 16'h0800, 8'h00, 0, 0, 4'b0001);
    frm(64, 16'h0800, 8'h01, 0, 0, 4'b0000);
    frm(120, 16'h0800, 8'h01, 1, 0, 4'b0000);
    rdc(`MVW_ADDR_WCSR, 32'h200);
    apb(1, `MVW_ADDR_WCSR, 32'h2);
    frm(120, 16'h0800, 8'h01, 1, 1, 4'b0000);
    rdc(`MVW_ADDR_WCSR, 32'h2);
    frm(120, 16'h0800, 8'h01, 1, 0, 4'b0001);
    rdc(`MVW_ADDR_WCSR, 32'h22);
    rdc(`MVW_ADDR_WCSR, 32'h22);
    apb(1, `MVW_ADDR_WCSR, 32'h24);
    rdc(`MVW_ADDR_WCSR, 32'h4);
    flt(0);
    frm(64, 16'h0800, 8'h01, 0, 0, 4'b0000);
    rdc(`MVW_ADDR_WCSR, 32'h4);
    flt(1);
    frm(64, 16'h0800, 8'h01, 0, 0, 4'b0001);
    rdc(`MVW_ADDR_WCSR, 32'h44);
    for (k = 0; k < 3; k++)
      apb(1, `MVW_ADDR_FILT, 32'h1);
    @(posedge sys_clk);
    soft_rst <= 1;
    @(posedge sys_clk);
    soft_rst <= 0;
    rdc(`MVW_ADDR_WCSR, 32'h0);
    rdc(`MVW_ADDR_TAG1, 32'h0);
    flt(1);
    apb(1, `MVW_ADDR_WCSR, 32'h4);
    frm(64, 16'h0800, 8'h01, 0, 0, 4'b0001);
    rdc(`MVW_ADDR_WCSR, 32'h44);
    finish_test;
  end
endmodule
